// *** hdl/etpif_pkg.sv ***
// Package with register map, field positions and reset values of the interrupt flag block
package etpif_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_IRQ_CONTROL = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_OPTION = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'hC;
    // irq_control_reg fields
    localparam int BIT_PORT_FLAG = 0;
    localparam int BIT_EXT_FLAG = 1;
    localparam int BIT_TIMER_FLAG = 2;
    localparam int BIT_PORT_EN = 3;
    localparam int BIT_EXT_EN = 4;
    localparam int BIT_TIMER_EN = 5;
    localparam int BIT_GLOBAL_EN = 7;
    // option register field
    localparam int BIT_EDGE_POL = 6;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] OPTION_RESET = 8'h00;
    localparam logic [7:0] TIMER_WRAP_FROM = 8'hFF;
    localparam logic [7:0] TIMER_WRAP_TO = 8'h00;
    // Event status register: one bit per event
    localparam int EVT_W = 3;
    localparam int EVT_PORT = 0;
    localparam int EVT_EXT = 1;
    localparam int EVT_TIMER = 2;
    localparam logic [EVT_W-1:0] MASK_RESET = 3'h0;
endpackage

// *** hdl/etpif_edge_det.sv ***
// Edge detector with selectable polarity for the external interrupt pin
`timescale 1ns/1ns
module etpif_edge_det (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic level_i,
    input wire logic rising_i,
    output logic edge_o
);
    logic last_level;
    logic seen;

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            last_level <= 1'b0;
            seen <= 1'b0;
        end else begin
            last_level <= level_i;
            seen <= 1'b1;
        end
    end

    // No edge before a first sample has been taken, so reset does not fake one
    assign edge_o = seen & (rising_i ? (level_i & ~last_level) : (~level_i & last_level));
endmodule

// *** hdl/etpif_top.sv ***
// Interrupt flag and enable logic for external edge, timer wrap and port change; wake logic for the external edge only
//
// The placing of the registers and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ns
module etpif_top (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [etpif_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [etpif_pkg::DATA_W-1:0] wb_dat_i,
    output logic [etpif_pkg::DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic ext_irq_pin_i,
    input wire logic [7:0] eight_bit_timer_count_i,
    input wire logic [3:0] upper_nibble_port_i,
    input wire logic port_read_i,
    input wire logic sleep_enter_i,
    output logic [3:0] port_latch_o,
    output logic asleep_o,
    output logic wake_o,
    output logic vector_o,
    output logic core_irq_o,
    output logic irq_o
);
    import etpif_pkg::*;

    logic [7:0] irq_control_reg;
    logic [7:0] option_reg;
    logic [EVT_W-1:0] irq_status;
    logic [EVT_W-1:0] irq_mask;
    logic [7:0] last_count;
    logic [3:0] port_latch;
    logic sleep_ext_enable;
    logic asleep;
    logic wake;
    logic vector;
    logic ack;
    logic [DATA_W-1:0] rdata;

    // Bus decode
    wire bus_req = wb_cyc_i & wb_stb_i & ~ack;
    wire bus_wr = bus_req & wb_we_i & wb_sel_i[0];
    wire bus_rd = bus_req & ~wb_we_i;
    wire sel_control = (wb_adr_i == OFS_IRQ_CONTROL);
    wire sel_option = (wb_adr_i == OFS_OPTION);
    wire sel_status = (wb_adr_i == OFS_IRQ_STATUS);
    wire sel_mask = (wb_adr_i == OFS_IRQ_MASK);
    wire wr_control = bus_wr & sel_control;
    wire wr_option = bus_wr & sel_option;
    wire wr_mask = bus_wr & sel_mask;
    wire rd_status = bus_rd & sel_status;

    // Events
    wire ext_edge;
    wire timer_wrap = (last_count == TIMER_WRAP_FROM) && (eight_bit_timer_count_i == TIMER_WRAP_TO);
    wire port_change = (upper_nibble_port_i != port_latch);
    wire [EVT_W-1:0] events = {timer_wrap, ext_edge, port_change};

    etpif_edge_det u_edge (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .level_i(ext_irq_pin_i),
        .rising_i(option_reg[BIT_EDGE_POL]),
        .edge_o(ext_edge)
    );

    // Flag next values: the event always wins over a software clear in the same cycle
    wire [7:0] wdata = wb_dat_i[7:0];
    wire [7:0] ctrl_base = wr_control ? wdata : irq_control_reg;
    wire [7:0] flag_set = {5'h00, timer_wrap, ext_edge, port_change};
    // Flags set independent of the enables; cleared only by software writes
    wire [7:0] next_control = ctrl_base | flag_set;

    wire glb_en = irq_control_reg[BIT_GLOBAL_EN];
    wire ext_pend = irq_control_reg[BIT_EXT_FLAG] & irq_control_reg[BIT_EXT_EN];
    wire tmr_pend = irq_control_reg[BIT_TIMER_FLAG] & irq_control_reg[BIT_TIMER_EN];
    wire port_pend = irq_control_reg[BIT_PORT_FLAG] & irq_control_reg[BIT_PORT_EN];
    wire any_pend = ext_pend | tmr_pend | port_pend;

    // Wake uses the enable as captured on entry to SLEEP
    wire wake_cond = asleep & sleep_ext_enable & irq_control_reg[BIT_EXT_FLAG];

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_control_reg <= CONTROL_RESET;
            option_reg <= OPTION_RESET;
            irq_mask <= MASK_RESET;
        end else begin
            irq_control_reg <= next_control;
            if (wr_option) begin
                option_reg <= wdata;
            end
            if (wr_mask) begin
                irq_mask <= wdata[EVT_W-1:0];
            end
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_status <= '0;
        end else begin
            // Read clears, a new event in the same cycle survives
            irq_status <= (rd_status ? '0 : irq_status) | events;
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            last_count <= 8'h00;
            port_latch <= 4'h0;
        end else begin
            last_count <= eight_bit_timer_count_i;
            if (port_read_i) begin
                port_latch <= upper_nibble_port_i;
            end
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            asleep <= 1'b0;
            sleep_ext_enable <= 1'b0;
            wake <= 1'b0;
            vector <= 1'b0;
        end else begin
            wake <= wake_cond;
            vector <= wake_cond & glb_en;
            if (wake_cond) begin
                asleep <= 1'b0;
            end else if (sleep_enter_i & ~asleep) begin
                asleep <= 1'b1;
                sleep_ext_enable <= irq_control_reg[BIT_EXT_EN];
            end
        end
    end

    // Read mux; unmapped addresses read zero and are still acknowledged
    wire [7:0] rd_byte = sel_control ? irq_control_reg :
                         sel_option ? option_reg :
                         sel_status ? {5'h00, irq_status} :
                         sel_mask ? {5'h00, irq_mask} : 8'h00;

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ack <= 1'b0;
            rdata <= '0;
        end else begin
            ack <= bus_req;
            rdata <= bus_rd ? {24'h000000, rd_byte} : '0;
        end
    end

    assign wb_ack_o = ack;
    assign wb_dat_o = rdata;
    assign port_latch_o = port_latch;
    assign asleep_o = asleep;
    assign wake_o = wake;
    assign vector_o = vector;
    assign core_irq_o = glb_en & any_pend;
    assign irq_o = |(irq_status & irq_mask);

    // History guard for the edge checks: the first cycle after reset has no earlier sample to compare
    logic hist_ok;

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hist_ok <= 1'b0;
        end else begin
            hist_ok <= 1'b1;
        end
    end

    // External edge
    ext_flag_sets_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        ext_edge |=> irq_control_reg[BIT_EXT_FLAG])
        else $error("edge did not set ext flag");
    edge_polarity_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        ext_edge |-> (ext_irq_pin_i == option_reg[BIT_EDGE_POL]))
        else $error("edge of wrong polarity");
    rising_edge_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (hist_ok && option_reg[BIT_EDGE_POL] && !$past(ext_irq_pin_i) && ext_irq_pin_i) |-> ext_edge)
        else $error("rising edge missed");
    falling_edge_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (hist_ok && !option_reg[BIT_EDGE_POL] && $past(ext_irq_pin_i) && !ext_irq_pin_i) |-> ext_edge)
        else $error("falling edge missed");
    no_edge_stable_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (hist_ok && $stable(ext_irq_pin_i)) |-> !ext_edge)
        else $error("edge on a steady pin");
    flag_sticky_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        $fell(irq_control_reg[BIT_EXT_FLAG]) |-> $past(wr_control))
        else $error("ext flag cleared by hw");
    hw_no_clear_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        !wr_control |=> ((irq_control_reg & $past(irq_control_reg)) == $past(irq_control_reg)))
        else $error("control bit cleared without a write");
    control_write_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (wr_control && flag_set == 8'h00) |=> (irq_control_reg == $past(wdata)))
        else $error("control write lost");
    ext_mask_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (!irq_control_reg[BIT_EXT_EN] && !tmr_pend && !port_pend) |-> !core_irq_o)
        else $error("ext not masked");
    ext_flag_free_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (ext_edge && !irq_control_reg[BIT_EXT_EN]) |=> irq_control_reg[BIT_EXT_FLAG])
        else $error("ext flag gated by enable");

    // Timer wrap
    timer_wrap_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        ($past(eight_bit_timer_count_i) == TIMER_WRAP_FROM && eight_bit_timer_count_i == TIMER_WRAP_TO)
        |=> irq_control_reg[BIT_TIMER_FLAG]) else $error("timer wrap missed");
    timer_flag_cause_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        $rose(irq_control_reg[BIT_TIMER_FLAG]) |-> ($past(timer_wrap) || $past(wr_control)))
        else $error("timer flag without wrap");
    timer_mask_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (!irq_control_reg[BIT_TIMER_EN] && !ext_pend && !port_pend) |-> !core_irq_o)
        else $error("timer not masked");
    timer_enable_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (glb_en && irq_control_reg[BIT_TIMER_EN] && irq_control_reg[BIT_TIMER_FLAG]) |-> core_irq_o)
        else $error("timer request missing");
    flag_free_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (timer_wrap && !irq_control_reg[BIT_TIMER_EN]) |=> irq_control_reg[BIT_TIMER_FLAG])
        else $error("flag gated by enable");

    // Port change
    port_change_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (upper_nibble_port_i != port_latch) |=> irq_control_reg[BIT_PORT_FLAG])
        else $error("port change missed");
    port_flag_cause_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        $rose(irq_control_reg[BIT_PORT_FLAG]) |-> ($past(port_change) || $past(wr_control)))
        else $error("port flag without change");
    port_mask_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (!irq_control_reg[BIT_PORT_EN] && !ext_pend && !tmr_pend) |-> !core_irq_o)
        else $error("port not masked");
    port_enable_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (glb_en && irq_control_reg[BIT_PORT_EN] && irq_control_reg[BIT_PORT_FLAG]) |-> core_irq_o)
        else $error("port request missing");
    port_latch_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        port_read_i |=> (port_latch_o == $past(upper_nibble_port_i)))
        else $error("port read not latched");
    latch_hold_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        !port_read_i |=> $stable(port_latch_o))
        else $error("latch moved without a read");
    port_free_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (port_change && !irq_control_reg[BIT_PORT_EN]) |=> irq_control_reg[BIT_PORT_FLAG])
        else $error("port flag gated by enable");

    // Core request
    core_req_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        core_irq_o == (irq_control_reg[7] & |(irq_control_reg[2:0] & {irq_control_reg[5:4], irq_control_reg[3]})))
        else $error("core request mismatch");
    global_mask_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        !glb_en |-> !core_irq_o)
        else $error("request without global enable");

    // Sleep and wake
    wake_needs_en_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        wake_o |-> $past(sleep_ext_enable))
        else $error("wake without prior enable");
    vector_gie_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        vector_o |-> (wake_o && $past(glb_en)))
        else $error("vector without global enable");
    wake_when_asleep_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        wake_o |-> $past(asleep_o))
        else $error("wake while awake");
    wake_leaves_sleep_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        wake_o |-> !asleep_o)
        else $error("still asleep after wake");
    sleep_capture_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (sleep_enter_i && !asleep_o) |=> (asleep_o && sleep_ext_enable == $past(irq_control_reg[BIT_EXT_EN])))
        else $error("sleep entry not captured");
    wake_prompt_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        wake_cond |=> wake_o)
        else $error("wake missed");
    vector_with_gie_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (wake_cond && glb_en) |=> vector_o)
        else $error("vector missed");
    no_vector_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        !(wake_cond && glb_en) |=> !vector_o)
        else $error("unexpected vector");
    wake_pulse_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        wake_o |=> !wake_o)
        else $error("wake longer than one cycle");
    no_wake_awake_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        !asleep_o |=> !wake_o)
        else $error("wake without sleep");

    // Status, mask and option registers
    status_sets_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (events != '0) |=> ((irq_status & $past(events)) == $past(events)))
        else $error("status event lost");
    status_clear_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (rd_status && events == '0) |=> (irq_status == '0))
        else $error("status not cleared by read");
    status_hold_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (!rd_status && events == '0) |=> $stable(irq_status))
        else $error("status changed on its own");
    irq_quiet_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (irq_mask == '0) |-> !irq_o)
        else $error("irq with all sources masked");
    mask_write_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        wr_mask |=> (irq_mask == $past(wb_dat_i[EVT_W-1:0])))
        else $error("mask write lost");
    mask_hold_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        !wr_mask |=> $stable(irq_mask))
        else $error("mask changed without a write");
    option_write_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        wr_option |=> (option_reg == $past(wdata)))
        else $error("option write lost");
    option_hold_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        !wr_option |=> $stable(option_reg))
        else $error("option changed without a write");

    // Register bus
    ack_pulse_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_answers_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("request not answered");
    ack_needs_req_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    rdata_idle_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        !wb_ack_o |-> (wb_dat_o == '0))
        else $error("read data outside ack");
    rdata_upper_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        wb_dat_o[DATA_W-1:8] == '0)
        else $error("upper read bits set");
    write_no_data_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        (wb_ack_o && $past(wb_we_i)) |-> (wb_dat_o == '0))
        else $error("read data on a write ack");

    // Main scenarios
    wake_cov: cover property (@(posedge clock_i) disable iff (!reset_n_i) wake_o && vector_o);
    wake_novec_cov: cover property (@(posedge clock_i) disable iff (!reset_n_i) wake_o && !vector_o);
    irq_cov: cover property (@(posedge clock_i) disable iff (!reset_n_i) core_irq_o ##1 wr_control);
    status_cov: cover property (@(posedge clock_i) disable iff (!reset_n_i) irq_o ##[1:4] rd_status);
    late_en_cov: cover property (@(posedge clock_i) disable iff (!reset_n_i)
        asleep_o && !sleep_ext_enable && irq_control_reg[BIT_EXT_FLAG]);
endmodule

// *** tb/etpif_far_model.sv ***
// Far-side model: external pin driver, port pins and the eight-bit timer
`timescale 1ns/1ns
module etpif_far_model (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic pin_i,
    input wire logic [3:0] port_i,
    input wire logic run_i,
    output logic ext_irq_pin_o,
    output logic [7:0] timer_o,
    output logic [3:0] port_o
);
    // Timer starts near the top so one short run gives exactly one wrap
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ext_irq_pin_o <= 1'b0;
            timer_o <= 8'hF8;
            port_o <= 4'h0;
        end else begin
            ext_irq_pin_o <= pin_i;
            port_o <= port_i;
            if (run_i) begin
                timer_o <= timer_o + 8'h01;
            end
        end
    end
endmodule

// *** tb/etpif_top_tb.sv ***
// Self-checking bench for the interrupt flag block
`timescale 1ns/1ns
module etpif_top_tb;
    import etpif_pkg::*;
    localparam logic [31:0] GE = 32'h1 << BIT_GLOBAL_EN;
    localparam logic [31:0] XE = 32'h1 << BIT_EXT_EN;
    localparam logic [31:0] XF = 32'h1 << BIT_EXT_FLAG;
    localparam logic [31:0] TE = 32'h1 << BIT_TIMER_EN;
    localparam logic [31:0] TF = 32'h1 << BIT_TIMER_FLAG;
    localparam logic [31:0] PE = 32'h1 << BIT_PORT_EN;
    localparam logic [31:0] PF = 32'h1 << BIT_PORT_FLAG;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic req = 1'b0;
    logic we = 1'b0;
    logic [ADDR_W-1:0] adr = 4'h0;
    logic [DATA_W-1:0] dat = 32'h0;
    logic [DATA_W-1:0] rdat;
    logic ack, pin_req = 1'b0, run = 1'b0, prd = 1'b0, slp = 1'b0;
    logic [3:0] port_req = 4'h0;
    logic pin, asleep, wake, vec, cirq, irq;
    logic [7:0] tmr;
    logic [3:0] port, latch;
    logic [31:0] q;
    int bad_count = 0;
    int n_tests = 0;
    int wakes = 0;
    int vecs = 0;

    always #5 clk = ~clk;

    etpif_far_model far (.clock_i(clk), .reset_n_i(rst_n), .pin_i(pin_req), .port_i(port_req), .run_i(run),
        .ext_irq_pin_o(pin), .timer_o(tmr), .port_o(port));
    etpif_top dut (.clock_i(clk), .reset_n_i(rst_n), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .ext_irq_pin_i(pin), .eight_bit_timer_count_i(tmr), .upper_nibble_port_i(port), .port_read_i(prd),
        .sleep_enter_i(slp), .port_latch_o(latch), .asleep_o(asleep), .wake_o(wake), .vector_o(vec),
        .core_irq_o(cirq), .irq_o(irq));

    always @(posedge clk) begin
        if (wake === 1'b1) wakes++;
        if (vec === 1'b1) vecs++;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Classic cycle: hold the request until ack is sampled, then release for a cycle
    task automatic wb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        req <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = rdat;
        req <= 1'b0;
        @(posedge clk);
        chk("ack drop", 32'h0, {31'h0, ack});
    endtask

    task automatic rd(input string nm, input logic [ADDR_W-1:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(nm, e, q);
    endtask

    task automatic pin_to(input logic v);
        pin_req <= v;
        repeat (5) @(posedge clk);
    endtask

    task automatic sleep_now();
        slp <= 1'b1;
        @(posedge clk);
        slp <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        wrap_up();
    end

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd("control", OFS_IRQ_CONTROL, {24'h0, CONTROL_RESET});
        rd("option", OFS_OPTION, {24'h0, OPTION_RESET});
        rd("mask", OFS_IRQ_MASK, {29'h0, MASK_RESET});
        rd("unmapped", 4'h2, 32'h0);
        pin_to(1'b1);
        rd("rise ignored", OFS_IRQ_CONTROL, 32'h0);
        pin_to(1'b0);
        rd("fall flag", OFS_IRQ_CONTROL, XF);
        wb(1'b1, OFS_IRQ_CONTROL, GE | XE | XF);
        chk("irq on", 32'h1, {31'h0, cirq});
        wb(1'b1, OFS_IRQ_CONTROL, GE | XF);
        chk("irq masked", 32'h0, {31'h0, cirq});
        wb(1'b1, OFS_IRQ_CONTROL, 32'h0);
        wb(1'b1, OFS_OPTION, 32'h1 << BIT_EDGE_POL);
        rd("option set", OFS_OPTION, 32'h1 << BIT_EDGE_POL);
        pin_to(1'b1);
        rd("rise flag", OFS_IRQ_CONTROL, XF);
        wb(1'b1, OFS_IRQ_CONTROL, 32'h0);
        pin_to(1'b0);
        rd("fall ignored", OFS_IRQ_CONTROL, 32'h0);
        wb(1'b0, OFS_IRQ_STATUS, 32'h0);
        wb(1'b1, OFS_IRQ_MASK, 32'h1 << EVT_TIMER);
        rd("mask set", OFS_IRQ_MASK, 32'h1 << EVT_TIMER);
        wb(1'b1, OFS_IRQ_CONTROL, GE | TE);
        run <= 1'b1;
        repeat (12) @(posedge clk);
        run <= 1'b0;
        repeat (3) @(posedge clk);
        chk("timer irq", 32'h1, {31'h0, cirq});
        chk("status irq", 32'h1, {31'h0, irq});
        rd("wrap flag", OFS_IRQ_CONTROL, GE | TE | TF);
        rd("status", OFS_IRQ_STATUS, 32'h1 << EVT_TIMER);
        rd("status clr", OFS_IRQ_STATUS, 32'h0);
        chk("status irq off", 32'h0, {31'h0, irq});
        wb(1'b1, OFS_IRQ_CONTROL, GE | TF);
        chk("timer off", 32'h0, {31'h0, cirq});
        wb(1'b1, OFS_IRQ_CONTROL, GE | PE);
        port_req <= 4'h5;
        repeat (5) @(posedge clk);
        rd("port flag", OFS_IRQ_CONTROL, GE | PE | PF);
        chk("port irq", 32'h1, {31'h0, cirq});
        prd <= 1'b1;
        @(posedge clk);
        prd <= 1'b0;
        wb(1'b1, OFS_IRQ_CONTROL, GE | PE);
        repeat (4) @(posedge clk);
        rd("port resync", OFS_IRQ_CONTROL, GE | PE);
        chk("latch", 32'h5, {28'h0, latch});
        wb(1'b1, OFS_IRQ_CONTROL, XE);
        sleep_now();
        pin_to(1'b1);
        chk("wake", 32'h1, wakes);
        chk("no vector", 32'h0, vecs);
        wb(1'b1, OFS_IRQ_CONTROL, GE | XE);
        pin_to(1'b0);
        sleep_now();
        pin_to(1'b1);
        chk("vector", 32'h1, vecs);
        wb(1'b1, OFS_IRQ_CONTROL, GE);
        pin_to(1'b0);
        sleep_now();
        wb(1'b1, OFS_IRQ_CONTROL, GE | XE);
        pin_to(1'b1);
        chk("late enable", 32'h2, wakes);
        chk("still asleep", 32'h1, {31'h0, asleep});
        wrap_up();
    end
endmodule
